// File: design/cpcd_pkg.sv
// Package for the processing clock divider configuration block.
// Holds register offsets, reset values, field positions and the carriers.
// Assumes an 8-bit register space, addressed by byte index.
package cpcd_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PLAYBACK_PROC_DIV   = 8'h0B;
    localparam logic [7:0] OFS_PLAYBACK_INSTR      = 8'h0F;
    localparam logic [7:0] OFS_PLAYBACK_INTERP     = 8'h10;
    localparam logic [7:0] OFS_RSVD_AFTER_INTERP   = 8'h11;
    localparam logic [7:0] OFS_RECORD_PROC_DIV     = 8'h12;
    localparam logic [7:0] OFS_RECORD_MOD_DIV      = 8'h13;
    localparam logic [7:0] OFS_RECORD_OVERSAMPLE   = 8'h14;
    localparam logic [7:0] OFS_RECORD_INSTR        = 8'h15;
    localparam logic [7:0] OFS_RECORD_DECIM        = 8'h16;
    localparam logic [7:0] OFS_RSVD_AFTER_DECIM_A  = 8'h17;
    localparam logic [7:0] OFS_RSVD_AFTER_DECIM_B  = 8'h18;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PLAYBACK_PROC_DIV   = 8'h01;
    localparam logic [7:0] RST_PLAYBACK_INSTR      = 8'h80;
    localparam logic [7:0] RST_PLAYBACK_INTERP     = 8'h08;
    localparam logic [7:0] RST_RECORD_PROC_DIV     = 8'h01;
    localparam logic [7:0] RST_RECORD_MOD_DIV      = 8'h01;
    localparam logic [7:0] RST_RECORD_OVERSAMPLE   = 8'h80;
    localparam logic [7:0] RST_RECORD_INSTR        = 8'h80;
    localparam logic [7:0] RST_RECORD_DECIM        = 8'h04;
    // Decoded ratios held during reset, matching the reset codes above
    localparam logic [10:0] RST_PLAYBACK_INSTR_COUNT    = 11'h200;
    localparam logic [4:0]  RST_PLAYBACK_INTERP_RATIO   = 5'h08;
    localparam logic [8:0]  RST_RECORD_OVERSAMPLE_RATIO = 9'h080;
    localparam logic [8:0]  RST_RECORD_INSTR_COUNT      = 9'h100;
    localparam logic [4:0]  RST_RECORD_DECIM_RATIO      = 5'h04;

    // ------------------------------------------------------------
    // Field positions and decode constants
    // ------------------------------------------------------------
    localparam int         DIV_RUN_BIT             = 7;
    localparam logic [7:0] RATIO4_MASK             = 8'h0F;
    localparam logic [7:0] DIV_ZERO_LEN            = 8'h80;
    localparam logic [7:0] RECORD_INSTR_MAX_CODE   = 8'hC0;
    localparam int         PLAYBACK_INSTR_SHIFT    = 2;
    localparam int         RECORD_INSTR_SHIFT      = 1;
    localparam logic [7:0] CNT_RESET               = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Decoded settings handed to the processing engines
    typedef struct packed {
        logic [10:0] playback_instr_count;
        logic [4:0]  playback_interp_ratio;
        logic [8:0]  record_oversample_ratio;
        logic [8:0]  record_instr_count;
        logic        record_instr_reserved;
        logic [4:0]  record_decim_ratio;
    } cpcd_ratio_t;

    // Divided clock ticks, one ref_clk cycle wide each
    typedef struct packed {
        logic playback_proc_tick;
        logic record_proc_tick;
        logic record_mod_tick;
    } cpcd_tick_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]  playback_proc_div_cfg;
        logic [7:0]  playback_instr_count_cfg;
        logic [7:0]  playback_interp_ratio_cfg;
        logic [7:0]  record_proc_divider_cfg;
        logic [7:0]  record_mod_divider_cfg;
        logic [7:0]  record_oversample_cfg;
        logic [7:0]  record_instr_count_cfg;
        logic [7:0]  record_decim_ratio_cfg;
        logic [2:0]  clkin_sync;
        logic        clkin_level;
        logic [7:0]  pp_cnt;
        logic [7:0]  rp_cnt;
        logic [7:0]  rm_cnt;
        cpcd_tick_t  ticks;
        cpcd_ratio_t ratios;
        logic [7:0]  rdata;
    } cpcd_state_t;

endpackage

// File: design/cpcd_clock_divider_cfg.sv
// Processing clock divider and ratio configuration for the codec engines.
// Assumes codec_clkin is an asynchronous clock pin, much slower than ref_clk,
// and that playback_mod_tick is a one-cycle strobe made on ref_clk.
// Divided clocks leave as one-cycle strobes on ref_clk, not square waves.
//
// Notes on behaviour
// - Playback instruction count is four times code; code zero gives 1024.
// - Interpolation ratio equals its 4-bit code; code zero gives 16.
// - Record processing divider bit 7 clear: bypass to playback processing clock.
// - Record processing divider divides by code; code zero divides by 128.
// - Record modulator divider bit 7 clear: record modulator equals playback modulator.
// - Record modulator divider divides by code; code zero divides by 128.
// - Record oversampling ratio equals code; code zero gives 256.
// - Record instruction count is twice code; zero and codes above C0 reserved.
// - Decimation ratio equals its 4-bit code; code zero gives 16.
// - Playback processing divider runs when bit 7 set; code zero means 128.
module cpcd_clock_divider_cfg
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    // Register port
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    // Clock sources
    input  wire logic                 codec_clkin,
    input  wire logic                 playback_mod_tick,
    // Divided clocks and decoded settings
    output cpcd_pkg::cpcd_tick_t      ticks,
    output cpcd_pkg::cpcd_ratio_t     ratios
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Divide length of a 7-bit divider code
    function automatic logic [7:0] div_len(input logic [7:0] cfg);
        div_len = (cfg[6:0] == 7'h00) ? cpcd_pkg::DIV_ZERO_LEN : {1'b0, cfg[6:0]};
    endfunction

    // Ratio of a 4-bit code, zero meaning 16
    function automatic logic [4:0] ratio4(input logic [7:0] cfg);
        ratio4 = (cfg[3:0] == 4'h0) ? 5'h10 : {1'b0, cfg[3:0]};
    endfunction

    // One divider step: returns next count, tick in bit 8
    // A code change mid-count is not guarded: a count past the new length wraps
    function automatic logic [8:0] div_step(input logic       run,
                                            input logic       edge_in,
                                            input logic [7:0] cnt,
                                            input logic [7:0] len);
        logic [7:0] cnt_inc;
        cnt_inc = cnt + 8'h01;
        if (!run)
            div_step = {1'b0, cpcd_pkg::CNT_RESET};
        else if (!edge_in)
            div_step = {1'b0, cnt};
        else if (cnt_inc == len)
            div_step = {1'b1, cpcd_pkg::CNT_RESET};
        else
            div_step = {1'b0, cnt_inc};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cpcd_pkg::cpcd_state_t state_ff;
    cpcd_pkg::cpcd_state_t nxt_state;

    logic                  clkin_rise;
    logic [8:0]            pp_step;
    logic [8:0]            rp_step;
    logic [8:0]            rm_step;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;

        // Register writes; reserved offsets and reserved nibble are dropped
        if (reg_wr)
        begin
            unique case (reg_addr)
                cpcd_pkg::OFS_PLAYBACK_PROC_DIV:
                    nxt_state.playback_proc_div_cfg = reg_wdata;
                cpcd_pkg::OFS_PLAYBACK_INSTR:
                    nxt_state.playback_instr_count_cfg = reg_wdata;
                cpcd_pkg::OFS_PLAYBACK_INTERP:
                    nxt_state.playback_interp_ratio_cfg = reg_wdata & cpcd_pkg::RATIO4_MASK;
                cpcd_pkg::OFS_RECORD_PROC_DIV:
                    nxt_state.record_proc_divider_cfg = reg_wdata;
                cpcd_pkg::OFS_RECORD_MOD_DIV:
                    nxt_state.record_mod_divider_cfg = reg_wdata;
                cpcd_pkg::OFS_RECORD_OVERSAMPLE:
                    nxt_state.record_oversample_cfg = reg_wdata;
                cpcd_pkg::OFS_RECORD_INSTR:
                    nxt_state.record_instr_count_cfg = reg_wdata;
                cpcd_pkg::OFS_RECORD_DECIM:
                    nxt_state.record_decim_ratio_cfg = reg_wdata & cpcd_pkg::RATIO4_MASK;
                // Reserved and unmapped offsets store nothing, so a stray write is harmless
                default:
                    nxt_state.rdata = state_ff.rdata;
            endcase
        end

        // Read data, registered; unmapped and reserved offsets read zero
        if (reg_rd)
        begin
            unique case (reg_addr)
                cpcd_pkg::OFS_PLAYBACK_PROC_DIV: nxt_state.rdata = state_ff.playback_proc_div_cfg;
                cpcd_pkg::OFS_PLAYBACK_INSTR:    nxt_state.rdata = state_ff.playback_instr_count_cfg;
                cpcd_pkg::OFS_PLAYBACK_INTERP:   nxt_state.rdata = state_ff.playback_interp_ratio_cfg;
                cpcd_pkg::OFS_RECORD_PROC_DIV:   nxt_state.rdata = state_ff.record_proc_divider_cfg;
                cpcd_pkg::OFS_RECORD_MOD_DIV:    nxt_state.rdata = state_ff.record_mod_divider_cfg;
                cpcd_pkg::OFS_RECORD_OVERSAMPLE: nxt_state.rdata = state_ff.record_oversample_cfg;
                cpcd_pkg::OFS_RECORD_INSTR:      nxt_state.rdata = state_ff.record_instr_count_cfg;
                cpcd_pkg::OFS_RECORD_DECIM:      nxt_state.rdata = state_ff.record_decim_ratio_cfg;
                default:                         nxt_state.rdata = 8'h00;
            endcase
        end

        // Pin high and low must each last two ref_clk cycles, or a rise is lost
        // Codec clock pin: three stages, a change counts once stages two and three agree
        nxt_state.clkin_sync = {state_ff.clkin_sync[1:0], codec_clkin};
        if (state_ff.clkin_sync[2] == state_ff.clkin_sync[1])
            nxt_state.clkin_level = state_ff.clkin_sync[2];
        clkin_rise = (state_ff.clkin_sync[2] == state_ff.clkin_sync[1])
                   && state_ff.clkin_sync[2] && !state_ff.clkin_level;

        // Playback processing divider on the codec clock
        pp_step = div_step(state_ff.playback_proc_div_cfg[cpcd_pkg::DIV_RUN_BIT],
                           clkin_rise, state_ff.pp_cnt,
                           div_len(state_ff.playback_proc_div_cfg));
        nxt_state.pp_cnt = pp_step[7:0];
        nxt_state.ticks.playback_proc_tick = pp_step[8];

        // Bypass copies the playback tick in the same cycle, keeping both engines in step
        // Record processing divider on the codec clock, or bypass
        rp_step = div_step(state_ff.record_proc_divider_cfg[cpcd_pkg::DIV_RUN_BIT],
                           clkin_rise, state_ff.rp_cnt,
                           div_len(state_ff.record_proc_divider_cfg));
        nxt_state.rp_cnt = rp_step[7:0];
        if (state_ff.record_proc_divider_cfg[cpcd_pkg::DIV_RUN_BIT])
            nxt_state.ticks.record_proc_tick = rp_step[8];
        else
            nxt_state.ticks.record_proc_tick = pp_step[8];

        // Record modulator divider on the record processing clock, or bypass
        rm_step = div_step(state_ff.record_mod_divider_cfg[cpcd_pkg::DIV_RUN_BIT],
                           nxt_state.ticks.record_proc_tick, state_ff.rm_cnt,
                           div_len(state_ff.record_mod_divider_cfg));
        nxt_state.rm_cnt = rm_step[7:0];
        if (state_ff.record_mod_divider_cfg[cpcd_pkg::DIV_RUN_BIT])
            nxt_state.ticks.record_mod_tick = rm_step[8];
        else
            nxt_state.ticks.record_mod_tick = playback_mod_tick;

        // Decoded ratios; these lag a register write by one cycle
        // Reserved record codes still decode to twice the code; the flag warns the engine
        nxt_state.ratios.playback_instr_count =
            (state_ff.playback_instr_count_cfg == 8'h00) ? 11'h400
            : 11'({state_ff.playback_instr_count_cfg, 2'b00});
        nxt_state.ratios.playback_interp_ratio =
            ratio4(state_ff.playback_interp_ratio_cfg);
        nxt_state.ratios.record_oversample_ratio =
            (state_ff.record_oversample_cfg == 8'h00) ? 9'h100
            : {1'b0, state_ff.record_oversample_cfg};
        nxt_state.ratios.record_instr_count =
            {state_ff.record_instr_count_cfg, 1'b0};
        nxt_state.ratios.record_instr_reserved =
            (state_ff.record_instr_count_cfg == 8'h00)
            || (state_ff.record_instr_count_cfg > cpcd_pkg::RECORD_INSTR_MAX_CODE);
        nxt_state.ratios.record_decim_ratio =
            ratio4(state_ff.record_decim_ratio_cfg);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Decoded ratios reset to the decode of the reset register values
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff                           <= '0;
            state_ff.playback_proc_div_cfg     <= cpcd_pkg::RST_PLAYBACK_PROC_DIV;
            state_ff.playback_instr_count_cfg  <= cpcd_pkg::RST_PLAYBACK_INSTR;
            state_ff.playback_interp_ratio_cfg <= cpcd_pkg::RST_PLAYBACK_INTERP;
            state_ff.record_proc_divider_cfg   <= cpcd_pkg::RST_RECORD_PROC_DIV;
            state_ff.record_mod_divider_cfg    <= cpcd_pkg::RST_RECORD_MOD_DIV;
            state_ff.record_oversample_cfg     <= cpcd_pkg::RST_RECORD_OVERSAMPLE;
            state_ff.record_instr_count_cfg    <= cpcd_pkg::RST_RECORD_INSTR;
            state_ff.record_decim_ratio_cfg    <= cpcd_pkg::RST_RECORD_DECIM;
            state_ff.ratios.playback_instr_count    <= cpcd_pkg::RST_PLAYBACK_INSTR_COUNT;
            state_ff.ratios.playback_interp_ratio   <= cpcd_pkg::RST_PLAYBACK_INTERP_RATIO;
            state_ff.ratios.record_oversample_ratio <= cpcd_pkg::RST_RECORD_OVERSAMPLE_RATIO;
            state_ff.ratios.record_instr_count      <= cpcd_pkg::RST_RECORD_INSTR_COUNT;
            state_ff.ratios.record_decim_ratio      <= cpcd_pkg::RST_RECORD_DECIM_RATIO;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs, straight from flip-flops
    // ------------------------------------------------------------
    // Read data holds until the next read strobe
    assign reg_rdata = state_ff.rdata;
    assign ticks     = state_ff.ticks;
    assign ratios    = state_ff.ratios;

endmodule

// File: bench/cpcd_monitor.sv
// Checker for the processing clock divider configuration block.
// Sees only the top ports; bound to the design below its endmodule.
module cpcd_monitor
(
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  nrst,
    // Register port
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [7:0]            reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic [7:0]            reg_rdata,
    // Clock sources and outputs
    input wire logic                  codec_clkin,
    input wire logic                  playback_mod_tick,
    input wire cpcd_pkg::cpcd_tick_t  ticks,
    input wire cpcd_pkg::cpcd_ratio_t ratios
);
    // ------------------------------------------------------------
    // Run bits of the record dividers, mirrored from writes
    // ------------------------------------------------------------
    logic rp_run_ff;
    logic rm_run_ff;
    // Mirror lands on the same edge as the design register
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rp_run_ff <= 1'h0;
            rm_run_ff <= 1'h0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == cpcd_pkg::OFS_RECORD_PROC_DIV) rp_run_ff <= reg_wdata[7];
            if (reg_addr == cpcd_pkg::OFS_RECORD_MOD_DIV) rm_run_ff <= reg_wdata[7];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // Decode of written codes, two cycles after the write edge
    // ------------------------------------------------------------
    a_play_instr_decode: assert property (
        reg_wr && reg_addr == cpcd_pkg::OFS_PLAYBACK_INSTR |-> ##2 ratios.playback_instr_count
        == {$past(reg_wdata, 2) == 8'h00, $past(reg_wdata, 2), 2'h0}) else $error("instr decode");
    a_interp_decode: assert property (
        reg_wr && reg_addr == cpcd_pkg::OFS_PLAYBACK_INTERP |-> ##2 ratios.playback_interp_ratio
        == {$past(reg_wdata[3:0], 2) == 4'h0, $past(reg_wdata[3:0], 2)}) else $error("interp");
    a_oversample_decode: assert property (
        reg_wr && reg_addr == cpcd_pkg::OFS_RECORD_OVERSAMPLE |-> ##2 ratios.record_oversample_ratio
        == {$past(reg_wdata, 2) == 8'h00, $past(reg_wdata, 2)}) else $error("oversample");
    a_rec_instr_decode: assert property (
        reg_wr && reg_addr == cpcd_pkg::OFS_RECORD_INSTR |-> ##2
        ratios.record_instr_count == {$past(reg_wdata, 2), 1'h0} && ratios.record_instr_reserved
        == ($past(reg_wdata, 2) == 8'h00 || $past(reg_wdata, 2) > 8'hC0)) else $error("rec instr");
    a_decim_decode: assert property (
        reg_wr && reg_addr == cpcd_pkg::OFS_RECORD_DECIM |-> ##2 ratios.record_decim_ratio
        == {$past(reg_wdata[3:0], 2) == 4'h0, $past(reg_wdata[3:0], 2)}) else $error("decim");
    // Bypass only checked when the run bit is clear now and was also clear two cycles back
    a_proc_bypass_copy: assert property (
        !rp_run_ff && !$past(rp_run_ff, 2) |-> ticks.record_proc_tick == ticks.playback_proc_tick)
        else $error("proc bypass");
    a_mod_bypass_copy: assert property (
        !rm_run_ff && !$past(rm_run_ff, 2) |-> ticks.record_mod_tick == $past(playback_mod_tick))
        else $error("mod bypass");
    a_tick_one_cycle: assert property (
        ticks.playback_proc_tick |=> !ticks.playback_proc_tick) else $error("tick width");
    a_reserved_reads_zero: assert property (
        reg_rd && reg_addr == cpcd_pkg::OFS_RSVD_AFTER_INTERP |-> ##2 reg_rdata == 8'h00)
        else $error("reserved read");
endmodule
bind cpcd_clock_divider_cfg cpcd_monitor cpcd_monitor_inst
(
    .ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .codec_clkin(codec_clkin),
    .playback_mod_tick(playback_mod_tick), .ticks(ticks), .ratios(ratios)
);

// File: bench/cpcd_clock_divider_cfg_tb.sv
// Self-checking bench for the processing clock divider configuration block.
// Drives the register port and both clock pins itself; no partner model.
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("BAD t=%0t got %0h exp %0h", $time, (got), (exp)); \
        end \
    end
module cpcd_clock_divider_cfg_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Stimulus, design and tick counters
    // ------------------------------------------------------------
    logic ref_clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic codec_clkin = 1'h0, playback_mod_tick = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [7:0] codes [5] = '{8'h00, 8'h01, 8'hC0, 8'hC1, 8'hFF};
    cpcd_pkg::cpcd_tick_t  ticks;
    cpcd_pkg::cpcd_ratio_t ratios;
    int miscompares = 0, n_tests = 0, pp_n = 0, rp_n = 0, rm_n = 0;
    initial forever #25 ref_clk = ~ref_clk;
    cpcd_clock_divider_cfg cpcd_clock_divider_cfg_inst
    (
        .ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .codec_clkin(codec_clkin),
        .playback_mod_tick(playback_mod_tick), .ticks(ticks), .ratios(ratios)
    );
    // Non-blocking so a task reading at an edge sees a settled count
    always @(posedge ref_clk)
    begin
        pp_n <= pp_n + int'(ticks.playback_proc_tick === 1'h1);
        rp_n <= rp_n + int'(ticks.record_proc_tick === 1'h1);
        rm_n <= rm_n + int'(ticks.record_mod_tick === 1'h1);
    end
    // ------------------------------------------------------------
    // Register port tasks: one-cycle strobes
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask
    // Data is looked at a full cycle late; it stands until the next read
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        @(posedge ref_clk);
        #1;
        `CHK(reg_rdata, exp)
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] ofs [8] = '{8'h0B, 8'h0F, 8'h10, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
        logic [7:0] rst [8] = '{8'h01, 8'h80, 8'h08, 8'h01, 8'h01, 8'h80, 8'h80, 8'h04};
        `CHK(ratios.playback_instr_count, 11'h200)
        `CHK(ratios.record_oversample_ratio, 9'h080)
        foreach (ofs[i]) rd_chk(ofs[i], rst[i]);
        rd_chk(8'h11, 8'h00);
        rd_chk(8'h17, 8'h00);
        rd_chk(8'h18, 8'h00);
        rd_chk(8'h20, 8'h00);
    endtask
    task automatic t_ratio(input logic [7:0] c);
        logic [3:0] n;
        n = c[3:0];
        // Codes keep every count a whole multiple of its ratio; upper nibbles stay zero
        wr(8'h0F, c);
        wr(8'h10, {4'h0, n});
        wr(8'h14, c);
        wr(8'h15, c);
        wr(8'h16, {4'h0, n});
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(ratios.playback_instr_count, (c == 8'h00) ? 11'h400 : 11'(c) * 11'h4)
        `CHK(ratios.playback_interp_ratio, (n == 4'h0) ? 5'h10 : 5'(n))
        `CHK(ratios.record_oversample_ratio, (c == 8'h00) ? 9'h100 : 9'(c))
        `CHK(ratios.record_instr_count, 9'(c) * 9'h2)
        `CHK(ratios.record_instr_reserved, (c == 8'h00 || c > 8'hC0))
        `CHK(ratios.record_decim_ratio, (n == 4'h0) ? 5'h10 : 5'(n))
        rd_chk(8'h15, c);
    endtask
    // Pin edges are 4 cycles apart so the synchroniser never merges two
    task automatic t_div(input logic [7:0] pd, rpd, rmd, input int edges, ep, er, em);
        int p0, r0, m0;
        wr(8'h0B, pd);
        wr(8'h12, rpd);
        wr(8'h13, rmd);
        repeat (4) @(posedge ref_clk);
        p0 = pp_n;
        r0 = rp_n;
        m0 = rm_n;
        repeat (edges)
        begin
            codec_clkin <= 1'h1;
            playback_mod_tick <= 1'h1;
            @(posedge ref_clk);
            playback_mod_tick <= 1'h0;
            repeat (3) @(posedge ref_clk);
            codec_clkin <= 1'h0;
            repeat (4) @(posedge ref_clk);
        end
        repeat (8) @(posedge ref_clk);
        `CHK(pp_n - p0, ep)
        `CHK(rp_n - r0, er)
        `CHK(rm_n - m0, em)
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard: running out counts as a mismatch
    initial
    begin
        repeat (50000) @(posedge ref_clk);
        miscompares++;
        results();
    end
    initial
    begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'h1;
        t_reset();
        foreach (codes[i]) t_ratio(codes[i]);
        t_div(8'h82, 8'h00, 8'h00, 4, 2, 2, 4);
        t_div(8'h82, 8'h83, 8'h82, 12, 6, 4, 2);
        t_div(8'h81, 8'h80, 8'h81, 128, 128, 1, 1);
        nrst <= 1'h0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'h1;
        t_reset();
        results();
    end
endmodule
